// ==== core/spi_port_map.svh ====
/*
  Register map, field positions, reset values and counts of the SPI port.
  Assumes a 32-bit APB with word-aligned registers; byte address is four times the index.
*/
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH

// Register indices and byte addresses
`define IDX_DATA 8'h21
`define IDX_CTRL 8'h22
`define IDX_CSR 8'h23
`define ADDR_W 10
`define ADDR_DATA 10'h084
`define ADDR_CTRL 10'h088
`define ADDR_CSR 10'h08c

// Control register fields
`define CR_IRQ_EN 7
`define CR_PORT_EN 6
`define CR_DIV_EN 5
`define CR_MASTER 4
`define CR_IDLE_LVL 3
`define CR_CAPTURE 2
`define CR_RATE_HI 1
`define CR_RATE_LO 0
`define CR_RESET 8'h00

// Control/status register fields
`define SR_DONE 7
`define SR_WRITE_COLLISION_FLAG 6
`define SR_OVR 5
`define SR_MODE_FAULT_FLAG 4
`define SR_OUT_DIS 2
`define SR_SOFT_MGT 1
`define SR_SOFT_LVL 0
`define SR_RESET 8'h00
`define SR_SW_MASK 8'h07

// Data reset value and shift edge counts
`define DATA_RESET 8'h00
`define LAST_EDGE 4'hf
`define EDGE_ZERO 4'h0

// Half periods of SCK in CPU cycles, per divider setting
`define HALF_DIV4 7'h02
`define HALF_DIV8 7'h04
`define HALF_DIV16 7'h08
`define HALF_DIV32 7'h10
`define HALF_DIV64 7'h20
`define HALF_DIV128 7'h40
`define HALF_ONE 7'h01

`endif

// ==== core/spi_port_pkg.sv ====
/*
  Types shared by the SPI port.
  Assumes the constants of spi_port_map.svh.
*/
package spi_port_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } mst_state_t;

endpackage : spi_port_pkg

// ==== core/spi_port.sv ====
/*
  SPI master/slave port with an APB register slave, halt wake-up and a shared interrupt.
  Assumes pin inputs synchronous to CLK except SCK and SS in slave mode, which are synchronised.
*/
// Function
// - In slave mode a completed transfer wakes the host from halt.
// - Several transfers completed before clearing the done flag set overrun.
// - Halt wake-up armed only if effective select is low at halt entry.
// - Done, fault and overrun share one request; only done exits halt.
// - Interrupt enable gates the request from done, fault or overrun flags.
// - Port enable resets low, connects pins, cleared on master-mode fault.
// - Master select drives SCK, swaps data lines, cleared on mode fault.
// - Idle clock level sets SCK idle state in master mode only; the slave path ignores it.
// - Capture edge select picks first or second SCK transition for capture.
// - Divider enable and rate bits choose SCK at CPU over 4 to 128.
// - Rate and divider bits have no effect in slave mode.
// - Done flag set at transfer end; cleared by status access then data access.
// - Data writes ignored while done is set until status is accessed.
// - Write collision flag set on data write during a transfer.
// - Overrun set when a byte completes while done still set; status read clears.
// - Mode fault set on select low in master mode; cleared by read then control write.
// - Output disable stops driving the data output line.
// - Soft select management ignores the pin and uses the soft level.
// - Data write loads the shift register and starts a master transfer.
// - Completed byte copied to a buffer unless done is still set; data reads return the buffer.
// - Each transfer shifts eight bits, most significant first.
// - A colliding write is discarded and the transfer continues.
`timescale 1ns/1ps
`include "spi_port_map.svh"

module spi_port
  import spi_port_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HALT,
  output logic IRQ,
  output logic WAKE_WAIT,
  output logic WAKE_HALT,
  output logic PINS_ALT,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE,
  input wire logic SS_N_I
);

  // ==========================================================================
  // Functions
  function automatic logic [6:0] half_period(input logic [2:0] sel);
    unique case (sel)
      3'h4: half_period = `HALF_DIV4;
      3'h0: half_period = `HALF_DIV8;
      3'h1: half_period = `HALF_DIV16;
      3'h6: half_period = `HALF_DIV32;
      3'h2: half_period = `HALF_DIV64;
      3'h3: half_period = `HALF_DIV128;
      default: half_period = `HALF_DIV4;
    endcase
  endfunction : half_period

  // ==========================================================================
  // Declarations
  logic [7:0] ctrl_ff;
  logic [7:0] csr_ff;
  logic [7:0] buf_ff;
  logic [7:0] shift_ff;
  logic rx_bit_ff;
  logic [3:0] edge_cnt_ff;
  logic [6:0] div_cnt_ff;
  logic sck_ff;
  mst_state_t state_ff;
  logic done_arm_ff;
  logic mode_fault_flag_arm_ff;
  logic halt_ff;
  logic halt_arm_ff;
  logic sck_meta_ff, sck_sync_ff, sck_prev_ff;
  logic ss_meta_ff, ss_sync_ff;
  logic [31:0] nxt_prdata;
  logic [7:0] nxt_received;

  logic setup, access, wr, rd;
  logic hit_data, hit_ctrl, hit_csr, mapped;
  logic irq_en, port_en, master, idle_lvl, capture_sel, out_dis, soft_mgt, soft_lvl;
  logic ss_eff_n, mode_fault, busy;
  logic data_wr, data_acc, data_load, collide, inhibit;
  logic edge_ev, leading, sample_ev, shift_ev, complete;
  logic ser_in, slave_sel;

  // ==========================================================================
  // APB decode
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  assign wr = access & PWRITE;
  assign rd = access & ~PWRITE;
  assign hit_data = (PADDR == `ADDR_DATA);
  assign hit_ctrl = (PADDR == `ADDR_CTRL);
  assign hit_csr = (PADDR == `ADDR_CSR);
  assign mapped = hit_data | hit_ctrl | hit_csr;
  assign PREADY = access;
  assign PSLVERR = access & ~mapped;

  assign irq_en = ctrl_ff[`CR_IRQ_EN];
  assign port_en = ctrl_ff[`CR_PORT_EN];
  assign master = ctrl_ff[`CR_MASTER];
  assign idle_lvl = ctrl_ff[`CR_IDLE_LVL];
  assign capture_sel = ctrl_ff[`CR_CAPTURE];
  assign out_dis = csr_ff[`SR_OUT_DIS];
  assign soft_mgt = csr_ff[`SR_SOFT_MGT];
  assign soft_lvl = csr_ff[`SR_SOFT_LVL];

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (hit_data) begin
      nxt_prdata[7:0] = buf_ff;
    end else if (hit_ctrl) begin
      nxt_prdata[7:0] = ctrl_ff;
    end else if (hit_csr) begin
      nxt_prdata[7:0] = csr_ff;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup) begin
      PRDATA <= nxt_prdata;
    end
  end

  // ==========================================================================
  // Select and fault detection
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sck_meta_ff <= 1'b0;
      sck_sync_ff <= 1'b0;
      sck_prev_ff <= 1'b0;
      ss_meta_ff <= 1'b1;
      ss_sync_ff <= 1'b1;
    end else begin
      sck_meta_ff <= SCK_I;
      sck_sync_ff <= sck_meta_ff;
      sck_prev_ff <= sck_sync_ff;
      ss_meta_ff <= SS_N_I;
      ss_sync_ff <= ss_meta_ff;
    end
  end

  assign ss_eff_n = soft_mgt ? soft_lvl : ss_sync_ff;
  assign mode_fault = port_en & master & ~ss_eff_n;
  assign slave_sel = port_en & ~master & ~ss_eff_n;

  // ==========================================================================
  // Data register access
  assign busy = master ? (state_ff == ST_RUN) : (slave_sel & (edge_cnt_ff != `EDGE_ZERO));
  assign data_wr = wr & hit_data;
  assign data_acc = access & hit_data;
  assign inhibit = csr_ff[`SR_DONE] & ~done_arm_ff;
  assign collide = data_wr & busy;
  assign data_load = data_wr & ~busy & ~inhibit;

  // ==========================================================================
  // Edge generation: master divider or synchronised slave SCK
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= ST_IDLE;
      div_cnt_ff <= `HALF_ONE;
      sck_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          sck_ff <= idle_lvl;
          div_cnt_ff <= half_period({ctrl_ff[`CR_DIV_EN], ctrl_ff[`CR_RATE_HI:`CR_RATE_LO]});
          if (data_load & master & port_en & ~mode_fault) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (mode_fault | ~master) begin
            state_ff <= ST_IDLE;
          end else if (div_cnt_ff == `HALF_ONE) begin
            div_cnt_ff <= half_period({ctrl_ff[`CR_DIV_EN], ctrl_ff[`CR_RATE_HI:`CR_RATE_LO]});
            sck_ff <= ~sck_ff;
            if (edge_cnt_ff == `LAST_EDGE) begin
              state_ff <= ST_IDLE;
            end
          end else begin
            div_cnt_ff <= div_cnt_ff - 7'h01;
          end
        end
      endcase
    end
  end

  // Slave path ignores rate bits entirely
  assign edge_ev = master ? ((state_ff == ST_RUN) & (div_cnt_ff == `HALF_ONE) & ~mode_fault)
                          : (slave_sel & (sck_sync_ff != sck_prev_ff));
  assign leading = ~edge_cnt_ff[0];
  assign sample_ev = edge_ev & (capture_sel ? ~leading : leading);
  assign shift_ev = edge_ev & (capture_sel ? leading : ~leading) & (edge_cnt_ff != `EDGE_ZERO);
  assign complete = edge_ev & (edge_cnt_ff == `LAST_EDGE);
  assign ser_in = master ? MISO_I : MOSI_I;

  always_comb begin
    nxt_received = capture_sel ? {shift_ff[6:0], ser_in} : {shift_ff[6:0], rx_bit_ff};
  end

  // ==========================================================================
  // Shift engine
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      shift_ff <= `DATA_RESET;
      rx_bit_ff <= 1'b0;
      edge_cnt_ff <= `EDGE_ZERO;
    end else begin
      if (data_load) begin
        shift_ff <= PWDATA[7:0];
        edge_cnt_ff <= `EDGE_ZERO;
      end else if (complete) begin
        shift_ff <= nxt_received;
        edge_cnt_ff <= `EDGE_ZERO;
      end else if (edge_ev) begin
        edge_cnt_ff <= edge_cnt_ff + 4'h1;
        if (shift_ev) begin
          shift_ff <= {shift_ff[6:0], rx_bit_ff};
        end
      end else if (!master && !slave_sel) begin
        edge_cnt_ff <= `EDGE_ZERO;
      end else if (master && state_ff == ST_IDLE) begin
        edge_cnt_ff <= `EDGE_ZERO;
      end
      if (sample_ev) begin
        rx_bit_ff <= ser_in;
      end
    end
  end

  // Receive buffer keeps the first byte after the last clear on overrun
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      buf_ff <= `DATA_RESET;
    end else if (complete && !csr_ff[`SR_DONE]) begin
      buf_ff <= nxt_received;
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_ff <= `CR_RESET;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_ff <= PWDATA[7:0];
        if (csr_ff[`SR_MODE_FAULT_FLAG] && !mode_fault_flag_arm_ff) begin
          ctrl_ff[`CR_PORT_EN] <= 1'b0;
          ctrl_ff[`CR_MASTER] <= 1'b0;
        end
      end
      if (mode_fault) begin
        ctrl_ff[`CR_PORT_EN] <= 1'b0;
        ctrl_ff[`CR_MASTER] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Status flags; a set in the same cycle as a clear wins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      csr_ff <= `SR_RESET;
      done_arm_ff <= 1'b0;
      mode_fault_flag_arm_ff <= 1'b0;
    end else begin
      if (wr && hit_csr) begin
        csr_ff[`SR_OUT_DIS:`SR_SOFT_LVL] <= PWDATA[`SR_OUT_DIS:`SR_SOFT_LVL];
      end
      if (access && hit_csr) begin
        done_arm_ff <= csr_ff[`SR_DONE] | csr_ff[`SR_WRITE_COLLISION_FLAG];
      end else if (data_acc) begin
        done_arm_ff <= 1'b0;
      end
      if (rd && hit_csr && csr_ff[`SR_MODE_FAULT_FLAG]) begin
        mode_fault_flag_arm_ff <= 1'b1;
      end else if (wr && hit_ctrl) begin
        mode_fault_flag_arm_ff <= 1'b0;
      end
      if (complete) begin
        csr_ff[`SR_DONE] <= 1'b1;
      end else if (data_acc && done_arm_ff) begin
        csr_ff[`SR_DONE] <= 1'b0;
      end
      if (collide) begin
        csr_ff[`SR_WRITE_COLLISION_FLAG] <= 1'b1;
      end else if (data_acc && done_arm_ff) begin
        csr_ff[`SR_WRITE_COLLISION_FLAG] <= 1'b0;
      end
      if (complete && csr_ff[`SR_DONE]) begin
        csr_ff[`SR_OVR] <= 1'b1;
      end else if (rd && hit_csr) begin
        csr_ff[`SR_OVR] <= 1'b0;
      end
      if (mode_fault) begin
        csr_ff[`SR_MODE_FAULT_FLAG] <= 1'b1;
      end else if (wr && hit_ctrl && mode_fault_flag_arm_ff) begin
        csr_ff[`SR_MODE_FAULT_FLAG] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Halt wake-up and interrupt request
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      halt_ff <= 1'b0;
      halt_arm_ff <= 1'b0;
    end else begin
      halt_ff <= HALT;
      if (HALT && !halt_ff) begin
        halt_arm_ff <= port_en & ~master & ~ss_eff_n;
      end else if (!HALT) begin
        halt_arm_ff <= 1'b0;
      end
    end
  end

  assign IRQ = irq_en & (csr_ff[`SR_DONE] | csr_ff[`SR_MODE_FAULT_FLAG] | csr_ff[`SR_OVR]);
  assign WAKE_WAIT = IRQ;
  assign WAKE_HALT = IRQ & HALT & halt_arm_ff & csr_ff[`SR_DONE] & ~master;

  // ==========================================================================
  // Pin drive
  assign PINS_ALT = port_en;
  assign SCK_OE = port_en & master;
  // Idle level straight from the register so enabling a master never glitches SCK
  assign SCK_O = (master && state_ff == ST_RUN) ? sck_ff : idle_lvl;
  assign MOSI_OE = port_en & master & ~out_dis;
  assign MOSI_O = shift_ff[7];
  assign MISO_OE = slave_sel & ~out_dis;
  assign MISO_O = shift_ff[7];

  // ==========================================================================
  // Assertions
  irq_gate_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    !irq_en |-> !IRQ) else $error("interrupt raised while disabled");
  fault_clears_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    mode_fault |=> !port_en && !master && csr_ff[`SR_MODE_FAULT_FLAG])
    else $error("mode fault did not disable port");
  done_set_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    complete |=> csr_ff[`SR_DONE]) else $error("done flag not set");
  wr_inhibit_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (data_wr && inhibit) |=> $stable(shift_ff) || $past(edge_ev))
    else $error("write accepted while done set");
  write_collision_flag_set_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    collide |=> csr_ff[`SR_WRITE_COLLISION_FLAG]) else $error("collision flag not set");
  ovr_set_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (complete && csr_ff[`SR_DONE]) |=> csr_ff[`SR_OVR] && $stable(buf_ff))
    else $error("overrun not flagged");
  sck_idle_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    ($fell(state_ff == ST_RUN) && master) |-> sck_ff == idle_lvl)
    else $error("SCK not back at idle level");
  out_dis_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    out_dis |-> !MOSI_OE && !MISO_OE) else $error("output driven while disabled");
  soft_sel_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    soft_mgt |-> ss_eff_n == soft_lvl) else $error("select not from soft level");
  wake_src_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    WAKE_HALT |-> csr_ff[`SR_DONE] && halt_arm_ff) else $error("bad halt wake");
  run_len_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    ($rose(state_ff == ST_RUN) && ctrl_ff[`CR_DIV_EN] && ctrl_ff[1:0] == 2'b00)
    |-> (state_ff == ST_RUN)[*8]) else $error("transfer ended early");

endmodule : spi_port

// ==== testbench/spi_far_slave.sv ====
/*
  Behavioural SPI slave standing on the far side of the port in master mode.
  Assumes SCK and MOSI are resolved pin levels and SEL_N is driven by the bench.
*/
`timescale 1ns/1ps

module spi_far_slave (
  input wire logic SCK,
  input wire logic MOSI,
  input wire logic SEL_N,
  input wire logic IDLE_CLOCK_LEVEL,
  input wire logic CAPTURE_EDGE_SELECT,
  input wire logic [7:0] TX,
  output logic MISO,
  output logic [7:0] RX
);
  // ==========================================================
  // Edge counting and capture
  int lead = 0;
  int trail = 0;
  int idx;
  logic last = 1'b0;
  wire logic mosi_d;

  // MOSI as it stood just before the SCK edge: the port reloads its shift
  // register on the same clock that makes its last capture edge
  assign #1 mosi_d = MOSI;

  initial RX = 8'h00;

  always @(negedge SEL_N) begin
    lead = 0;
    trail = 0;
  end

  always @(SCK) begin
    if (!SEL_N) begin
      last = MISO;
      if (SCK !== IDLE_CLOCK_LEVEL) lead++;
      else trail++;
      if ((SCK !== IDLE_CLOCK_LEVEL) == !CAPTURE_EDGE_SELECT) RX = {RX[6:0], mosi_d};
    end
  end

  // ==========================================================
  // Serial output, never a stale level once released
  always_comb begin
    idx = CAPTURE_EDGE_SELECT ? lead - 1 : trail;
    if (SEL_N || idx < 0 || idx > 7) MISO = ~last;
    else MISO = TX[7 - idx];
  end
endmodule : spi_far_slave

// ==== testbench/spi_port_tb.sv ====
/*
  Self-checking bench of the SPI port in master and slave modes over APB.
  Assumes the register map header and a far-side slave model.
*/
`timescale 1ns/1ps
`include "spi_port_map.svh"

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end

module spi_port_tb;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [9:0] PADDR = 10'h000;
  logic [31:0] PWDATA = 32'h00000000;
  logic HALT = 1'b0;
  logic SS_N_I = 1'b1;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, IRQ, WAKE_WAIT, WAKE_HALT, PINS_ALT;
  logic SCK_O, SCK_OE, MOSI_O, MOSI_OE, MISO_O, MISO_OE;
  logic sel_n = 1'b1;
  logic mclk = 1'b0;
  logic mosi_drv = 1'b1;
  logic [7:0] mrx = 8'h00;
  logic idle_clock_level = 1'b0;
  logic capture_edge_select = 1'b0;
  logic miso_far, sck_q, rerr;
  logic [7:0] far_tx = 8'h00;
  logic [7:0] far_rx, ctl, dv;
  logic [31:0] rdat;
  logic [2:0] codes [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
  int halves [6] = '{2, 4, 8, 16, 32, 64};
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int cnt = 0;
  int gap = 0;
  int nedge = 0;
  wire sck_w = SCK_OE ? SCK_O : (idle_clock_level ^ mclk);
  wire mosi_w = MOSI_OE ? MOSI_O : mosi_drv;
  wire miso_w = MISO_OE ? MISO_O : miso_far;

  spi_port dut (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .HALT(HALT), .IRQ(IRQ), .WAKE_WAIT(WAKE_WAIT),
    .WAKE_HALT(WAKE_HALT), .PINS_ALT(PINS_ALT), .SCK_I(sck_w), .SCK_O(SCK_O),
    .SCK_OE(SCK_OE), .MOSI_I(mosi_w), .MOSI_O(MOSI_O), .MOSI_OE(MOSI_OE),
    .MISO_I(miso_w), .MISO_O(MISO_O), .MISO_OE(MISO_OE), .SS_N_I(SS_N_I));

  spi_far_slave far (.SCK(sck_w), .MOSI(mosi_w), .SEL_N(sel_n), .IDLE_CLOCK_LEVEL(idle_clock_level),
    .CAPTURE_EDGE_SELECT(capture_edge_select), .TX(far_tx), .MISO(miso_far), .RX(far_rx));

  // ==========================================================
  // Clock, timeout and serial clock monitor
  always #25 CLK = ~CLK;

  always @(posedge CLK) begin
    cyc <= cyc + 1;
    cnt <= cnt + 1;
    sck_q <= SCK_O;
    if (SCK_O !== sck_q) begin
      gap <= cnt + 1;
      cnt <= 0;
      nedge <= nedge + 1;
    end
    if (cyc == 60000) begin
      n_errors++;
      give_verdict;
    end
  end

  task automatic give_verdict;
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Bus access tasks
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] wd);
    int n;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h000000, wd};
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n == 20) n_errors++;
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb

  task automatic rchk(input logic [9:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rdat, {24'h000000, e})
  endtask : rchk

  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (IRQ !== e && n < 3000) begin
      @(posedge CLK);
      n++;
    end
    // One more edge so the SCK monitor has counted the last edge
    @(posedge CLK);
    `CHK(IRQ, e)
  endtask : wait_irq

  // Bench acts as far master: mode 0, SCK half period of 8 CPU cycles
  task automatic slv_byte(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin
      mosi_drv <= b[k];
      repeat (8) @(posedge CLK);
      mrx <= {mrx[6:0], miso_w};
      mclk <= 1'b1;
      repeat (8) @(posedge CLK);
      mclk <= 1'b0;
    end
    repeat (8) @(posedge CLK);
  endtask : slv_byte

  // ==========================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge CLK);
    ARST_N <= 1'b1;
    @(posedge CLK);
    rchk(`ADDR_CTRL, `CR_RESET);
    rchk(`ADDR_CSR, `SR_RESET);
    apb(1'b0, 10'h090, 8'h00);
    `CHK(rerr, 1'b1)
    `CHK(PINS_ALT, 1'b0)
    for (int i = 0; i < 6; i++) begin
      idle_clock_level = i[0];
      capture_edge_select = i[1];
      ctl = {2'b11, codes[i][2], 1'b1, idle_clock_level, capture_edge_select, codes[i][1:0]};
      dv = 8'h96 ^ {i[3:0], i[3:0]};
      far_tx = 8'h3c + 8'(i);
      apb(1'b1, `ADDR_CTRL, 8'h00);
      apb(1'b1, `ADDR_CTRL, ctl);
      sel_n = 1'b0;
      apb(1'b1, `ADDR_DATA, dv);
      nedge = 0;
      wait_irq(1'b1);
      `CHK(nedge, 16)
      `CHK(gap, halves[i])
      `CHK(SCK_O, idle_clock_level)
      `CHK(far_rx, dv)
      sel_n = 1'b1;
      rchk(`ADDR_CSR, 8'h80);
      rchk(`ADDR_DATA, far_tx);
      `CHK(IRQ, 1'b0)
      rchk(`ADDR_CSR, 8'h00);
    end
    idle_clock_level = 1'b0;
    capture_edge_select = 1'b0;
    far_tx = 8'h5a;
    apb(1'b1, `ADDR_CTRL, 8'h00);
    apb(1'b1, `ADDR_CTRL, 8'hd0);
    sel_n = 1'b0;
    apb(1'b1, `ADDR_DATA, 8'hc3);
    wait_irq(1'b1);
    sel_n = 1'b1;
    apb(1'b1, `ADDR_DATA, 8'h11);
    nedge = 0;
    repeat (20) @(posedge CLK);
    `CHK(nedge, 0)
    rchk(`ADDR_CSR, 8'h80);
    sel_n = 1'b0;
    apb(1'b1, `ADDR_DATA, 8'h3e);
    apb(1'b1, `ADDR_DATA, 8'h77);
    wait_irq(1'b1);
    `CHK(far_rx, 8'h3e)
    sel_n = 1'b1;
    rchk(`ADDR_CSR, 8'hc0);
    rchk(`ADDR_DATA, 8'h5a);
    rchk(`ADDR_CSR, 8'h00);
    apb(1'b1, `ADDR_CSR, 8'h03);
    SS_N_I <= 1'b0;
    repeat (6) @(posedge CLK);
    rchk(`ADDR_CSR, 8'h03);
    apb(1'b1, `ADDR_CSR, 8'h02);
    wait_irq(1'b1);
    `CHK(WAKE_WAIT, 1'b1)
    `CHK(WAKE_HALT, 1'b0)
    rchk(`ADDR_CTRL, 8'h80);
    apb(1'b1, `ADDR_CSR, 8'h03);
    rchk(`ADDR_CSR, 8'h13);
    apb(1'b1, `ADDR_CTRL, 8'h80);
    rchk(`ADDR_CSR, 8'h03);
    `CHK(IRQ, 1'b0)
    SS_N_I <= 1'b1;
    apb(1'b1, `ADDR_CTRL, 8'h50);
    `CHK(MOSI_OE, 1'b1)
    `CHK(PINS_ALT, 1'b1)
    apb(1'b1, `ADDR_CSR, 8'h07);
    `CHK(MOSI_OE, 1'b0)
    `CHK(SCK_OE, 1'b1)
    rchk(`ADDR_CSR, 8'h07);
    // Slave mode with halt wake-up, then an overrun
    apb(1'b1, `ADDR_CTRL, 8'h00);
    apb(1'b1, `ADDR_CSR, 8'h00);
    apb(1'b1, `ADDR_CTRL, 8'he3);
    apb(1'b1, `ADDR_DATA, 8'ha5);
    SS_N_I <= 1'b0;
    repeat (4) @(posedge CLK);
    HALT <= 1'b1;
    repeat (2) @(posedge CLK);
    slv_byte(8'h3c);
    `CHK(mrx, 8'ha5)
    `CHK(IRQ, 1'b1)
    `CHK(WAKE_HALT, 1'b1)
    HALT <= 1'b0;
    slv_byte(8'h69);
    `CHK(mrx, 8'h3c)
    rchk(`ADDR_CSR, 8'ha0);
    rchk(`ADDR_DATA, 8'h3c);
    rchk(`ADDR_CSR, 8'h00);
    SS_N_I <= 1'b1;
    give_verdict;
  end
endmodule : spi_port_tb
